// *** verification/cmd_decoder_tb_top.sv ***
/*
  Self-checking bench for the address map decoder.
  Assumes cmd_pkg is compiled first and cmd_per_model is available.
*/
`timescale 1ns/100ps

`define CMD_CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module cmd_decoder_tb_top;
  import cmd_pkg::*;
  localparam int ROM_KB = 128;
  localparam int RAM_KB = 6;
  localparam logic [4:0] ROM = 5'h01, RAM = 5'h02, PER = 5'h04, EXT = 5'h08, BAD = 5'h10;
  int fail_count = 0;
  int check_count = 0;
  logic i_clk, i_rst_n, i_table_call_instruction_exec, i_trap, i_nmi_ack, i_sr_wr, i_dbg_mode;
  logic [31:0] i_next_pc, i_status_word, i_sr_wdata, i_pc_base, i_pc_disp, i_op_base, i_op_disp;
  logic [4:0] i_sr_wr_num, i_sr_rd_num, i_pin_mode_ctl, o_sel;
  logic [15:0] i_table_offset, i_per_rdata, o_per_wdata, lw;
  logic i_vec_req, i_acc_valid, i_acc_fetch, i_acc_write, i_acc_word, i_per_byte_reg;
  cmd_src_type i_vec_src;
  logic [5:0] i_vec_index;
  logic [31:0] i_acc_addr, i_acc_wdata, o_sr_rdata, o_data_addr, o_acc_rdata, o_ext_wdata;
  logic [25:0] o_pc_next, o_table_addr, o_vec_addr, o_ext_addr;
  logic o_vec_valid, o_boot_fetch, o_port_mode, o_acc_ready, o_acc_done, o_ext_valid;
  logic o_ext_write, o_per_valid, o_per_write;
  logic [11:0] o_per_addr, la, pa;
  logic [1:0] o_per_wstrb, ls;
  logic [7:0] hits;

  cmd_decoder #(.ROM_KB(ROM_KB), .RAM_KB(RAM_KB)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_table_call_instruction_exec(i_table_call_instruction_exec), .i_trap(i_trap), .i_nmi_ack(i_nmi_ack),
    .i_next_pc(i_next_pc), .i_status_word(i_status_word), .i_sr_wr(i_sr_wr),
    .i_sr_wr_num(i_sr_wr_num), .i_sr_wdata(i_sr_wdata), .i_dbg_mode(i_dbg_mode),
    .i_sr_rd_num(i_sr_rd_num), .o_sr_rdata(o_sr_rdata), .i_pc_base(i_pc_base),
    .i_pc_disp(i_pc_disp), .i_op_base(i_op_base), .i_op_disp(i_op_disp),
    .i_table_offset(i_table_offset), .o_pc_next(o_pc_next), .o_data_addr(o_data_addr),
    .o_table_addr(o_table_addr), .i_vec_req(i_vec_req), .i_vec_src(i_vec_src),
    .i_vec_index(i_vec_index), .o_vec_valid(o_vec_valid), .o_vec_addr(o_vec_addr),
    .o_boot_fetch(o_boot_fetch), .i_pin_mode_ctl(i_pin_mode_ctl), .o_port_mode(o_port_mode),
    .i_acc_valid(i_acc_valid), .i_acc_addr(i_acc_addr), .i_acc_fetch(i_acc_fetch),
    .i_acc_write(i_acc_write), .i_acc_word(i_acc_word), .i_acc_wdata(i_acc_wdata),
    .o_acc_ready(o_acc_ready), .o_acc_done(o_acc_done), .o_sel(o_sel),
    .o_acc_rdata(o_acc_rdata), .o_ext_valid(o_ext_valid), .o_ext_write(o_ext_write),
    .o_ext_addr(o_ext_addr), .o_ext_wdata(o_ext_wdata), .i_per_rdata(i_per_rdata),
    .i_per_byte_reg(i_per_byte_reg), .o_per_valid(o_per_valid), .o_per_write(o_per_write),
    .o_per_addr(o_per_addr), .o_per_wdata(o_per_wdata), .o_per_wstrb(o_per_wstrb));

  cmd_per_model per_u (.i_clk(i_clk), .i_per_valid(o_per_valid), .i_per_write(o_per_write),
    .i_per_addr(o_per_addr), .i_per_wdata(o_per_wdata), .i_per_wstrb(o_per_wstrb),
    .o_per_rdata(i_per_rdata), .o_per_byte_reg(i_per_byte_reg), .o_last_addr(la),
    .o_prev_addr(pa), .o_last_wdata(lw), .o_last_wstrb(ls), .o_hits(hits));

  // ----------------------------------------
  // Clock and bus tasks
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // System register write, one cycle strobe
  task automatic sr_wr(input logic [4:0] n, input logic [31:0] d);
    @(negedge i_clk);
    i_sr_wr = 1'b1;
    i_sr_wr_num = n;
    i_sr_wdata = d;
    @(negedge i_clk);
    i_sr_wr = 1'b0;
  endtask

  // Read data is registered, so look one edge after the select
  task automatic sr_chk(input logic [4:0] n, input logic [31:0] ex);
    @(negedge i_clk);
    i_sr_rd_num = n;
    @(posedge i_clk);
    #1 `CMD_CHK("sr_rdata", ex, o_sr_rdata)
  endtask

  // Hardware save pulse: bit 2 table call, bit 1 trap, bit 0 nmi
  task automatic save(input logic [2:0] k, input logic [31:0] pc, input logic [31:0] sw);
    @(negedge i_clk);
    {i_table_call_instruction_exec, i_trap, i_nmi_ack} = k;
    i_next_pc = pc;
    i_status_word = sw;
    @(negedge i_clk);
    {i_table_call_instruction_exec, i_trap, i_nmi_ack} = 3'h0;
  endtask

  task automatic vec(input cmd_src_type s, input logic [5:0] ix, input logic [25:0] ex);
    @(negedge i_clk);
    i_vec_req = 1'b1;
    i_vec_src = s;
    i_vec_index = ix;
    @(posedge i_clk);
    #1 `CMD_CHK("vec_valid", 1'b1, o_vec_valid)
    `CMD_CHK("vec_addr", ex, o_vec_addr)
    @(negedge i_clk);
    i_vec_req = 1'b0;
  endtask

  // One access; checks region, latency, forward pulse and peripheral cycle count
  task automatic acc(input logic [31:0] a, input logic f, w, wd, input logic [4:0] sel,
                     input int lat);
    int n;
    logic [7:0] h0;
    logic ev;
    n = 1;
    h0 = hits;
    @(negedge i_clk);
    {i_acc_valid, i_acc_fetch, i_acc_write, i_acc_word} = {1'b1, f, w, wd};
    i_acc_addr = a;
    @(posedge i_clk);
    // Forward pulse stands only for the cycle after the taking edge
    #1 ev = o_ext_valid;
    @(negedge i_clk);
    i_acc_valid = 1'b0;
    i_acc_addr = ~a;
    while (o_acc_done !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      #1 n++;
    end
    `CMD_CHK("acc_latency", lat, n)
    `CMD_CHK("acc_sel", sel, o_sel)
    `CMD_CHK("ext_valid", sel == EXT, ev)
    `CMD_CHK("per_cycles", (sel == PER) ? (wd ? 8'h02 : 8'h01) : 8'h00, hits - h0)
  endtask

  // Arithmetic outputs are registered one edge after the operands
  task automatic arith(input logic [31:0] pb, pd, ob, od, input logic [15:0] t);
    @(negedge i_clk);
    {i_pc_base, i_pc_disp, i_op_base, i_op_disp, i_table_offset} = {pb, pd, ob, od, t};
    @(posedge i_clk);
    #1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_rst_n, i_table_call_instruction_exec, i_trap, i_nmi_ack, i_sr_wr, i_dbg_mode, i_vec_req} = 7'h0;
    {i_acc_valid, i_acc_fetch, i_acc_write, i_acc_word} = 4'h0;
    {i_next_pc, i_status_word, i_sr_wdata, i_acc_addr, i_acc_wdata} = '0;
    {i_pc_base, i_pc_disp, i_op_base, i_op_disp, i_table_offset} = '0;
    {i_sr_wr_num, i_sr_rd_num, i_pin_mode_ctl, i_vec_index} = '0;
    i_vec_src = CMD_SRC_RESET;
    repeat (20) @(negedge i_clk);
    `CMD_CHK("port_mode_rst", 1'b1, o_port_mode)
    i_rst_n = 1'b1;
    @(posedge i_clk);
    #1 `CMD_CHK("boot_fetch", 1'b1, o_boot_fetch)
    `CMD_CHK("boot_vec", 26'h0, o_vec_addr)
    // All five pin controls must be set before external devices show up
    @(negedge i_clk);
    i_pin_mode_ctl = 5'h1f;
    @(posedge i_clk);
    #1 `CMD_CHK("port_mode_ctl", 1'b0, o_port_mode)
    @(negedge i_clk);
    i_pin_mode_ctl = 5'h1e;
    @(posedge i_clk);
    #1 `CMD_CHK("port_mode_part", 1'b1, o_port_mode)
    sr_wr(5'h10, 32'hffffffff);
    sr_chk(5'h10, 32'h03ffffff);
    sr_wr(5'h11, 32'hffffffff);
    sr_chk(5'h11, 32'h000000ff);
    save(3'b100, 32'hfc000102, 32'hffffff5a);
    sr_chk(5'h10, 32'h00000102);
    sr_chk(5'h11, 32'h0000005a);
    save(3'b010, 32'h0ffffff0, 32'h000001a7);
    sr_chk(5'h12, 32'h03fffff0);
    sr_chk(5'h13, 32'h000000a7);
    sr_wr(5'h12, 32'h00000000);
    sr_chk(5'h12, 32'h03fffff0);
    i_dbg_mode = 1'b1;
    sr_wr(5'h12, 32'hf2345678);
    sr_chk(5'h12, 32'h02345678);
    sr_wr(5'h13, 32'hffffffff);
    sr_chk(5'h13, 32'h000000ff);
    save(3'b001, 32'hfc000200, 32'h00000080);
    sr_chk(5'h02, 32'h00000200);
    sr_chk(5'h03, 32'h00000080);
    sr_chk(5'h12, 32'h02345678);
    sr_wr(5'h14, 32'hffffffff);
    sr_chk(5'h14, 32'h03fffffe);
    arith(32'h03fffffe, 32'h00000004, 32'hfffffffe, 32'h00000004, 16'h0004);
    `CMD_CHK("pc_next", 26'h0000002, o_pc_next)
    `CMD_CHK("data_addr", 32'h00000002, o_data_addr)
    `CMD_CHK("table_addr", 26'h0000002, o_table_addr)
    for (int i = 0; i < 7; i++) vec(cmd_src_type'(i[2:0]), 6'h00, 26'(i * 16));
    vec(CMD_SRC_MASK, 6'h00, 26'h0000080);
    vec(CMD_SRC_MASK, 6'h2c, 26'h0000340);
    acc(32'h00000000, 1'b1, 1'b0, 1'b0, ROM, 1);
    i_acc_wdata = 32'h5a5a0001;
    acc(32'h00000010, 1'b0, 1'b1, 1'b0, EXT, 1);
    `CMD_CHK("ext_write", 1'b1, o_ext_write)
    `CMD_CHK("ext_wdata", 32'h5a5a0001, o_ext_wdata)
    acc(32'(ROM_KB * 1024 - 2), 1'b0, 1'b0, 1'b0, ROM, 1);
    acc(32'(ROM_KB * 1024), 1'b1, 1'b0, 1'b0, BAD, 1);
    acc(32'h01000000, 1'b0, 1'b0, 1'b0, BAD, 1);
    acc(32'hfc100004, 1'b0, 1'b0, 1'b1, EXT, 1);
    `CMD_CHK("ext_addr", 26'h0100004, o_ext_addr)
    acc(32'h03fff000 - 32'(RAM_KB * 1024), 1'b0, 1'b1, 1'b0, RAM, 1);
    acc(32'h03ffeffe - 32'(RAM_KB * 1024), 1'b0, 1'b0, 1'b0, BAD, 1);
    acc(32'h03fff046, 1'b1, 1'b0, 1'b0, BAD, 1);
    acc(32'hfffff046, 1'b0, 1'b0, 1'b1, PER, 3);
    `CMD_CHK("word_rdata", 32'ha046a044, o_acc_rdata)
    `CMD_CHK("low_first", 12'h044, pa)
    acc(32'h03fff046, 1'b0, 1'b0, 1'b0, PER, 2);
    `CMD_CHK("half_rdata", 32'h0000a046, o_acc_rdata)
    acc(32'h03fff104, 1'b0, 1'b0, 1'b0, PER, 2);
    `CMD_CHK("byte_rdata", 32'h00000004, o_acc_rdata)
    i_acc_wdata = 32'h00001234;
    acc(32'h03fff104, 1'b0, 1'b1, 1'b0, PER, 2);
    `CMD_CHK("byte_wstrb", 2'b01, ls)
    `CMD_CHK("byte_wdata", 8'h34, lw[7:0])
    report_and_stop();
  end

  // Whole run is under two hundred cycles
  initial begin
    #(50 * 3000);
    fail_count++;
    report_and_stop();
  end
endmodule

// *** verification/cmd_per_model.sv ***
/*
  Behavioural peripheral register block on the far side of the decoder.
  Assumes it answers combinationally while i_per_valid is high, on i_clk.
*/
`timescale 1ns/100ps

module cmd_per_model (
  // Clock
  input wire logic i_clk,
  // Peripheral cycle from the decoder
  input wire logic i_per_valid,
  input wire logic i_per_write,
  input wire logic [11:0] i_per_addr,
  input wire logic [15:0] i_per_wdata,
  input wire logic [1:0] i_per_wstrb,
  // Answer and log
  output logic [15:0] o_per_rdata,
  output logic o_per_byte_reg,
  output logic [11:0] o_last_addr,
  output logic [11:0] o_prev_addr,
  output logic [15:0] o_last_wdata,
  output logic [1:0] o_last_wstrb,
  output logic [7:0] o_hits
);
  logic [15:0] pat = 16'h0000;

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // Outside a cycle the data bus churns, so a stale value never passes
  assign o_per_rdata = i_per_valid ? {4'ha, i_per_addr} : pat;
  assign o_per_byte_reg = (i_per_addr[11:8] == 4'h1);

  // Cycle log, one entry per halfword cycle seen
  initial begin
    o_hits = 8'h00;
    o_last_addr = 12'h000;
    o_prev_addr = 12'h000;
    o_last_wdata = 16'h0000;
    o_last_wstrb = 2'h0;
  end
  always @(posedge i_clk) begin
    pat <= pat + 16'h1357;
    if (i_per_valid) begin
      o_hits <= o_hits + 8'h01;
      o_prev_addr <= o_last_addr;
      o_last_addr <= i_per_addr;
      if (i_per_write) begin
        o_last_wdata <= i_per_wdata;
        o_last_wstrb <= i_per_wstrb;
      end
    end
  end
endmodule

// *** verilog/cmd_decoder.sv ***
/*
  Address space decoder and status save registers of a 32-bit CPU.
  Assumes the core presents one access per request, that the peripheral
  block answers combinationally in the cycle of o_per_valid, and that
  i_pin_mode_ctl comes from registers clocked by i_clk.
*/
`timescale 1ns/100ps
`include "cmd_defines.svh"

module cmd_decoder #(
  parameter int ROM_KB = 128,
  parameter int RAM_KB = 6
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Status saves
  input wire logic i_table_call_instruction_exec,
  input wire logic i_trap,
  input wire logic i_nmi_ack,
  input wire logic [31:0] i_next_pc,
  input wire logic [31:0] i_status_word,
  // System register port
  input wire logic i_sr_wr,
  input wire logic [4:0] i_sr_wr_num,
  input wire logic [31:0] i_sr_wdata,
  input wire logic i_dbg_mode,
  input wire logic [4:0] i_sr_rd_num,
  output logic [31:0] o_sr_rdata,
  // Address arithmetic
  input wire logic [31:0] i_pc_base,
  input wire logic [31:0] i_pc_disp,
  input wire logic [31:0] i_op_base,
  input wire logic [31:0] i_op_disp,
  input wire logic [15:0] i_table_offset,
  output logic [25:0] o_pc_next,
  output logic [31:0] o_data_addr,
  output logic [25:0] o_table_addr,
  // Handler vectors
  input wire logic i_vec_req,
  input wire cmd_pkg::cmd_src_type i_vec_src,
  input wire logic [5:0] i_vec_index,
  output logic o_vec_valid,
  output logic [25:0] o_vec_addr,
  output logic o_boot_fetch,
  // Bus pin mode
  input wire logic [4:0] i_pin_mode_ctl,
  output logic o_port_mode,
  // CPU access port
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic i_acc_fetch,
  input wire logic i_acc_write,
  input wire logic i_acc_word,
  input wire logic [31:0] i_acc_wdata,
  output logic o_acc_ready,
  output logic o_acc_done,
  output logic [4:0] o_sel,
  output logic [31:0] o_acc_rdata,
  // External bus controller
  output logic o_ext_valid,
  output logic o_ext_write,
  output logic [25:0] o_ext_addr,
  output logic [31:0] o_ext_wdata,
  // Peripheral registers
  input wire logic [15:0] i_per_rdata,
  input wire logic i_per_byte_reg,
  output logic o_per_valid,
  output logic o_per_write,
  output logic [11:0] o_per_addr,
  output logic [15:0] o_per_wdata,
  output logic [1:0] o_per_wstrb
);
  import cmd_pkg::*;

  // ----------------------------------------
  // Variant boundaries
  // ----------------------------------------
  // Sizes are parameters so one decoder serves every variant
  localparam logic [25:0] ROM_PHYS_END = 26'(ROM_KB) * `CMD_KB;
  localparam logic [25:0] RAM_PHYS_LO = `CMD_PER_LO - 26'(RAM_KB) * `CMD_KB;

  typedef struct packed {
    cmd_fsm_type fsm;
    logic started;
    logic boot_fetch;
    logic [25:0] ct_pc;
    logic [7:0] ct_psw;
    logic [25:0] db_pc;
    logic [7:0] db_psw;
    logic [25:0] nmi_pc;
    logic [7:0] nmi_psw;
    logic [25:0] table_base_pointer;
    logic [31:0] sr_rdata;
    logic [25:0] pc_next;
    logic [31:0] data_addr;
    logic [25:0] table_addr;
    logic vec_valid;
    logic [25:0] vec_addr;
    logic port_mode;
    logic acc_done;
    logic [4:0] sel;
    logic [31:0] acc_rdata;
    logic ext_valid;
    logic ext_write;
    logic [25:0] ext_addr;
    logic [31:0] ext_wdata;
    logic per_valid;
    logic per_write;
    logic [11:0] per_addr;
    logic [15:0] per_wdata;
    logic [15:0] hi_wdata;
    logic [15:0] lo_rdata;
    logic per_word;
  } cmd_state_type;

  cmd_state_type s;
  cmd_state_type next_s;

  // ----------------------------------------
  // Region decode
  // ----------------------------------------
  // One region per access from the 26-bit physical address
  function automatic cmd_region_type decode(input logic [25:0] a, input logic fetch,
                                            input logic write);
    cmd_region_type r;
    r = CMD_REG_BAD;
    if (a <= `CMD_ROM_END) begin
      if (write && !fetch) begin
        r = CMD_REG_EXT;
      end else if (a < ROM_PHYS_END) begin
        r = CMD_REG_ROM;
      end else begin
        r = CMD_REG_BAD;
      end
    end else if (a <= `CMD_EXT_HI) begin
      r = CMD_REG_EXT;
    end else if (a >= `CMD_PER_LO) begin
      r = fetch ? CMD_REG_BAD : CMD_REG_PER;
    end else if (a >= RAM_PHYS_LO && a <= `CMD_RAM_HI) begin
      r = CMD_REG_RAM;
    end else begin
      r = CMD_REG_BAD;
    end
    return r;
  endfunction

  // One-hot select from the decoded region
  function automatic logic [4:0] onehot(input cmd_region_type r);
    logic [4:0] v;
    v = 5'h00;
    case (r)
      CMD_REG_ROM: v[`CMD_SEL_ROM] = 1'b1;
      CMD_REG_RAM: v[`CMD_SEL_RAM] = 1'b1;
      CMD_REG_PER: v[`CMD_SEL_PER] = 1'b1;
      CMD_REG_EXT: v[`CMD_SEL_EXT] = 1'b1;
      default: v[`CMD_SEL_BAD] = 1'b1;
    endcase
    return v;
  endfunction

  // Handler table lookup, 16-byte spacing
  function automatic logic [25:0] vector(input cmd_src_type src, input logic [5:0] idx);
    logic [25:0] v;
    v = `CMD_VEC_RESET;
    case (src)
      CMD_SRC_RESET: v = `CMD_VEC_RESET;
      CMD_SRC_NMI: v = `CMD_VEC_NMI;
      CMD_SRC_WDT1: v = `CMD_VEC_WDT1;
      CMD_SRC_WDT2: v = `CMD_VEC_WDT2;
      CMD_SRC_TRAP_LO: v = `CMD_VEC_TRAP_LO;
      CMD_SRC_TRAP_HI: v = `CMD_VEC_TRAP_HI;
      CMD_SRC_ILGOP: v = `CMD_VEC_ILGOP;
      default: begin
        v = `CMD_VEC_MASK_BASE + (26'(idx) << `CMD_VEC_SHIFT);
        // Out-of-range index clamps to the last entry rather than wild jumps
        if (v > `CMD_VEC_MASK_LAST) begin
          v = `CMD_VEC_MASK_LAST;
        end
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Operand accesses use only the low 26 bits
  cmd_region_type acc_region;
  logic [25:0] acc_phys;
  assign acc_phys = i_acc_addr[25:0];
  assign acc_region = decode(acc_phys, i_acc_fetch, i_acc_write);

  always_comb begin
    next_s = s;
    next_s.boot_fetch = !s.started;
    next_s.started = 1'b1;
    next_s.acc_done = 1'b0;
    next_s.ext_valid = 1'b0;
    next_s.per_valid = 1'b0;
    next_s.vec_valid = i_vec_req;
    next_s.vec_addr = s.started ? vector(i_vec_src, i_vec_index) : `CMD_VEC_RESET;
    // Pins stay in port mode until all five controls select control mode
    next_s.port_mode = ~&i_pin_mode_ctl;
    // Wrap arithmetic: 26-bit program, 32-bit operand, 26-bit table
    next_s.pc_next = 26'(i_pc_base + i_pc_disp);
    next_s.data_addr = 32'(i_op_base + i_op_disp);
    next_s.table_addr = s.table_base_pointer + 26'(i_table_offset);

    // Software writes; a hardware save in the same cycle wins below
    if (i_sr_wr) begin
      case (i_sr_wr_num)
        `CMD_SR_CT_PC: next_s.ct_pc = i_sr_wdata[25:0];
        `CMD_SR_CT_PSW: next_s.ct_psw = i_sr_wdata[7:0];
        `CMD_SR_DB_PC: if (i_dbg_mode) next_s.db_pc = i_sr_wdata[25:0];
        `CMD_SR_DB_PSW: if (i_dbg_mode) next_s.db_psw = i_sr_wdata[7:0];
        `CMD_SR_NMI_PC: next_s.nmi_pc = i_sr_wdata[25:0];
        `CMD_SR_NMI_PSW: next_s.nmi_psw = i_sr_wdata[7:0];
        `CMD_SR_TABLE_BASE_POINTER: next_s.table_base_pointer = {i_sr_wdata[25:1], 1'b0};
        default: ;
      endcase
    end
    if (i_table_call_instruction_exec) begin
      next_s.ct_pc = i_next_pc[25:0];
      next_s.ct_psw = i_status_word[7:0];
    end
    if (i_trap) begin
      next_s.db_pc = i_next_pc[25:0];
      next_s.db_psw = i_status_word[7:0];
    end
    if (i_nmi_ack) begin
      next_s.nmi_pc = i_next_pc[25:0];
      next_s.nmi_psw = i_status_word[7:0];
    end

    // Read port, reserved bits padded with zero
    case (i_sr_rd_num)
      `CMD_SR_CT_PC: next_s.sr_rdata = {`CMD_PC_PAD, s.ct_pc};
      `CMD_SR_CT_PSW: next_s.sr_rdata = {`CMD_PSW_PAD, s.ct_psw};
      `CMD_SR_DB_PC: next_s.sr_rdata = {`CMD_PC_PAD, s.db_pc};
      `CMD_SR_DB_PSW: next_s.sr_rdata = {`CMD_PSW_PAD, s.db_psw};
      `CMD_SR_NMI_PC: next_s.sr_rdata = {`CMD_PC_PAD, s.nmi_pc};
      `CMD_SR_NMI_PSW: next_s.sr_rdata = {`CMD_PSW_PAD, s.nmi_psw};
      `CMD_SR_TABLE_BASE_POINTER: next_s.sr_rdata = {`CMD_PC_PAD, s.table_base_pointer};
      default: next_s.sr_rdata = 32'h00000000;
    endcase

    // Access sequencing; peripheral words take two halfword cycles
    case (s.fsm)
      CMD_IDLE: begin
        if (i_acc_valid) begin
          next_s.sel = onehot(acc_region);
          next_s.acc_rdata = 32'h00000000;
          case (acc_region)
            CMD_REG_EXT: begin
              next_s.ext_valid = 1'b1;
              next_s.ext_write = i_acc_write;
              next_s.ext_addr = acc_phys;
              next_s.ext_wdata = i_acc_wdata;
              next_s.acc_done = 1'b1;
            end
            CMD_REG_PER: begin
              next_s.per_valid = 1'b1;
              next_s.per_write = i_acc_write;
              next_s.per_wdata = i_acc_wdata[15:0];
              next_s.hi_wdata = i_acc_wdata[31:16];
              next_s.per_word = i_acc_word;
              if (i_acc_word) begin
                // Lower half first with the two low address bits dropped
                next_s.per_addr = {acc_phys[11:2], 2'b00};
                next_s.fsm = CMD_PER_HIGH;
              end else begin
                next_s.per_addr = acc_phys[11:0];
                next_s.fsm = CMD_PER_END;
              end
            end
            default: next_s.acc_done = 1'b1;
          endcase
        end
      end
      CMD_PER_HIGH: begin
        next_s.lo_rdata = i_per_byte_reg ? {8'h00, i_per_rdata[7:0]} : i_per_rdata;
        next_s.per_valid = 1'b1;
        next_s.per_addr = {s.per_addr[11:2], 2'b10};
        next_s.per_wdata = s.hi_wdata;
        next_s.fsm = CMD_PER_END;
      end
      CMD_PER_END: begin
        // Undefined upper byte of a byte register is returned as zero
        // A halfword at an odd halfword address is not the tail of a word
        if (s.per_word) begin
          next_s.acc_rdata = {(i_per_byte_reg ? {8'h00, i_per_rdata[7:0]} : i_per_rdata),
                              s.lo_rdata};
        end else begin
          next_s.acc_rdata = {16'h0000,
                              (i_per_byte_reg ? {8'h00, i_per_rdata[7:0]} : i_per_rdata)};
        end
        next_s.acc_done = 1'b1;
        next_s.fsm = CMD_IDLE;
      end
      default: next_s.fsm = CMD_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.port_mode <= 1'b1;
      s.sel <= 5'h00;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_acc_ready = (s.fsm == CMD_IDLE);
  assign o_sr_rdata = s.sr_rdata;
  assign o_pc_next = s.pc_next;
  assign o_data_addr = s.data_addr;
  assign o_table_addr = s.table_addr;
  assign o_vec_valid = s.vec_valid;
  assign o_vec_addr = s.vec_addr;
  assign o_boot_fetch = s.boot_fetch;
  assign o_port_mode = s.port_mode;
  assign o_acc_done = s.acc_done;
  assign o_sel = s.sel;
  assign o_acc_rdata = s.acc_rdata;
  assign o_ext_valid = s.ext_valid;
  assign o_ext_write = s.ext_write;
  assign o_ext_addr = s.ext_addr;
  assign o_ext_wdata = s.ext_wdata;
  assign o_per_valid = s.per_valid;
  assign o_per_write = s.per_write;
  assign o_per_addr = s.per_addr;
  assign o_per_wdata = s.per_wdata;
  // Byte registers store only the low lane on a halfword write
  assign o_per_wstrb = (s.per_valid && s.per_write) ? {!i_per_byte_reg, 1'b1} : 2'b00;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_table_call_instruction_save: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_table_call_instruction_exec |=> s.ct_pc == $past(i_next_pc[25:0]) && s.ct_psw == $past(i_status_word[7:0]))
    else $error("table call save wrong");
  a_ct_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_sr_rd_num == `CMD_SR_CT_PSW |=> o_sr_rdata[31:8] == 24'h000000)
    else $error("table call status reserved bits set");
  a_trap_save: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_trap |=> s.db_pc == $past(i_next_pc[25:0]) && s.db_psw == $past(i_status_word[7:0]))
    else $error("trap save wrong");
  a_trap_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_sr_rd_num == `CMD_SR_DB_PC |=> o_sr_rdata[31:26] == 6'h00)
    else $error("trap pc reserved bits set");
  a_table_base_pointer_even: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_sr_rd_num == `CMD_SR_TABLE_BASE_POINTER |=> o_sr_rdata[0] == 1'b0 && o_sr_rdata[31:26] == 6'h00)
    else $error("table base pointer odd or high");
  a_boot_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_boot_fetch |-> o_vec_addr == `CMD_VEC_RESET && $past(!s.started))
    else $error("boot fetch not at reset entry");
  a_pc_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_pc_next == 26'($past(i_pc_base) + $past(i_pc_disp)))
    else $error("program counter wrap wrong");
  a_low_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_acc_valid && o_acc_ready && i_acc_write && !i_acc_fetch && i_acc_addr[25:0] <= `CMD_ROM_END
    |=> o_sel[`CMD_SEL_EXT] && o_ext_valid)
    else $error("low write not sent external");
  a_per_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_acc_valid && o_acc_ready && i_acc_fetch && i_acc_addr[25:0] >= `CMD_PER_LO
    |=> o_sel[`CMD_SEL_BAD] && !o_per_valid)
    else $error("peripheral fetch not refused");
  a_word_split: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_acc_valid && o_acc_ready && i_acc_word && acc_region == CMD_REG_PER
    |=> o_per_valid && o_per_addr[1:0] == 2'b00 ##1 o_per_valid && o_per_addr[1:0] == 2'b10
    ##1 o_acc_done)
    else $error("peripheral word split wrong");
  a_one_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_acc_done |-> $onehot(o_sel))
    else $error("region select not one-hot");
  a_nmi_vector: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_vec_req && i_vec_src == CMD_SRC_NMI && s.started |=> o_vec_valid && o_vec_addr == `CMD_VEC_NMI)
    else $error("nmi handler address wrong");
endmodule

// *** verilog/cmd_defines.svh ***
/*
  Address map, vector table and system register numbers for the address
  map decoder. Assumes inclusion by bare name from the design files.
*/
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

// ----------------------------------------
// Physical address map (26-bit)
// ----------------------------------------
`define CMD_ROM_END 26'h00fffff
`define CMD_EXT_LO 26'h0100000
`define CMD_EXT_HI 26'h0ffffff
`define CMD_RAM_LO 26'h3ff0000
`define CMD_RAM_HI 26'h3ffefff
`define CMD_PER_LO 26'h3fff000
`define CMD_KB 26'h0000400

// ----------------------------------------
// Handler addresses
// ----------------------------------------
`define CMD_VEC_RESET 26'h0000000
`define CMD_VEC_NMI 26'h0000010
`define CMD_VEC_WDT1 26'h0000020
`define CMD_VEC_WDT2 26'h0000030
`define CMD_VEC_TRAP_LO 26'h0000040
`define CMD_VEC_TRAP_HI 26'h0000050
`define CMD_VEC_ILGOP 26'h0000060
`define CMD_VEC_MASK_BASE 26'h0000080
`define CMD_VEC_MASK_LAST 26'h0000340
`define CMD_VEC_SHIFT 4

// ----------------------------------------
// System register numbers and widths
// ----------------------------------------
`define CMD_SR_NMI_PC 5'h02
`define CMD_SR_NMI_PSW 5'h03
`define CMD_SR_CT_PC 5'h10
`define CMD_SR_CT_PSW 5'h11
`define CMD_SR_DB_PC 5'h12
`define CMD_SR_DB_PSW 5'h13
`define CMD_SR_TABLE_BASE_POINTER 5'h14
`define CMD_PC_PAD 6'h00
`define CMD_PSW_PAD 24'h000000

// ----------------------------------------
// Region select bit positions
// ----------------------------------------
`define CMD_SEL_ROM 0
`define CMD_SEL_RAM 1
`define CMD_SEL_PER 2
`define CMD_SEL_EXT 3
`define CMD_SEL_BAD 4

`endif

// *** verilog/cmd_pkg.sv ***
/*
  Types shared by the address map decoder.
  Assumes cmd_defines.svh is present alongside.
*/
package cmd_pkg;
  // Decoded target region
  typedef enum logic [2:0] {
    CMD_REG_ROM, CMD_REG_RAM, CMD_REG_PER, CMD_REG_EXT, CMD_REG_BAD
  } cmd_region_type;

  // Handler source of an acknowledged event
  typedef enum logic [2:0] {
    CMD_SRC_RESET, CMD_SRC_NMI, CMD_SRC_WDT1, CMD_SRC_WDT2,
    CMD_SRC_TRAP_LO, CMD_SRC_TRAP_HI, CMD_SRC_ILGOP, CMD_SRC_MASK
  } cmd_src_type;

  // Peripheral access sequencer
  typedef enum logic [1:0] {
    CMD_IDLE, CMD_PER_HIGH, CMD_PER_END
  } cmd_fsm_type;
endpackage
